// file: hw/vefm_params.svh
// Purpose: constants of the video error flag and mask bank
// Assumes: host register port with 8-bit word address, 16-bit data
// Notes:   definitions only
`ifndef VEFM_PARAMS_SVH
`define VEFM_PARAMS_SVH

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define VEFM_ADDR_W        8
`define VEFM_DATA_W        16
`define VEFM_MASK_ADDR     8'h1A
`define VEFM_FLAGS_ADDR    8'h1B
`define VEFM_MASK_RESET    11'h000
`define VEFM_FLAGS_RESET   11'h000
`define VEFM_NUM_FLAGS     11

// ------------------------------------------------------------
// flag and mask bit positions (shared by both registers)
// ------------------------------------------------------------
`define VEFM_ACTIVE_END_BIT     0
`define VEFM_ACTIVE_START_BIT   1
`define VEFM_LINE_NUMBER_BIT    2
`define VEFM_LUMA_LINE_CRC_BIT  3
`define VEFM_CHROMA_CRC_BIT     4
`define VEFM_LUMA_CSUM_BIT      5
`define VEFM_CHROMA_CSUM_BIT    6
`define VEFM_LOCK_BIT           7
`define VEFM_ACTIVE_PIC_BIT     8
`define VEFM_FULL_FIELD_BIT     9
`define VEFM_STANDARD_BIT       10

// ------------------------------------------------------------
// timing reference code word layout
// ------------------------------------------------------------
`define VEFM_XYZ_ONE_BIT   9
`define VEFM_XYZ_F_BIT     8
`define VEFM_XYZ_V_BIT     7
`define VEFM_XYZ_H_BIT     6
`define VEFM_XYZ_P3_BIT    5
`define VEFM_XYZ_P2_BIT    4
`define VEFM_XYZ_P1_BIT    3
`define VEFM_XYZ_P0_BIT    2
`endif

// file: hw/vefm_pkg.sv
// Purpose: types of the video error flag and mask bank
// Assumes: vefm_params.svh is not used here; every width is a literal
// Notes:   widths of compared words are fixed here
package vefm_pkg;

    // host register access, one request per cycle
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } vefm_host_req_t;

    // timing reference code check, both channels
    typedef struct packed {
        logic       valid;
        logic       is_8bit;
        logic [9:0] luma_xyz;
        logic [9:0] chroma_xyz;
    } vefm_trs_t;

    // line number compare
    typedef struct packed {
        logic        valid;
        logic [10:0] computed;
        logic [10:0] received;
    } vefm_line_t;

    // luma line crc compare
    typedef struct packed {
        logic        valid;
        logic [17:0] computed;
        logic [17:0] received;
    } vefm_crc_t;

    // payload identifier standard compare
    typedef struct packed {
        logic       valid;
        logic [5:0] received;
        logic [5:0] determined;
    } vefm_std_t;

    // detector events from outside this bank
    typedef struct packed {
        logic chroma_crc_err;
        logic luma_csum_err;
        logic chroma_csum_err;
        logic active_pic_crc_err;
        logic full_field_crc_err;
        logic locked;
    } vefm_ext_t;

endpackage : vefm_pkg

// file: hw/vefm_error_bank.sv
// Purpose: error flags, mask register and combined error output
// Assumes: all inputs but reset_n synchronous to clk (parallel word clock)
// Notes:   flags are sticky and clear when the host reads them
//          bits 15..11 of both host words read as zero
//          data_error follows the flags in the same cycle
//
// Overview of operation
// R1: in HD, line number mismatch sets flag bit 2
// R2: bad timing code word, 8 or 10 bit, sets end code flag bit 0
// R3: bad timing code word, 8 or 10 bit, sets start code flag bit 1
// R4: in HD only luma timing codes are checked, chroma ignored
// R5: timing code flags only while flywheel enable is high
// R6: luma line crc mismatch sets flag bit 3
// R7: mask register at 1Ah, bits 10..0 read/write reset 0, rest 0
// R8: mask bits follow the flag bit positions 10 down to 0
// R9: payload standard disagreeing with own standard sets flag 10
// R10: a set mask bit keeps its flag out of the combined error
// R11: flags are read-only to host and zero after reset
// R12: line crc flags only in HD, rate indicator low
`include "vefm_params.svh"

module vefm_error_bank #(
    parameter int NUM_FLAGS = `VEFM_NUM_FLAGS  // flag count
) (
    input  wire logic                    clk,      // word clock
    input  wire logic                    reset_n,  // async reset
    input  wire vefm_pkg::vefm_host_req_t host_req, // host request
    output logic [15:0]                  rd_data,  // read data
    input  wire logic                    definition_rate_indicator, // 1=SD
    input  wire logic                    flywheel_enable_control, // fw on
    input  wire vefm_pkg::vefm_trs_t     trs,      // timing codes
    input  wire vefm_pkg::vefm_line_t    line_chk, // line numbers
    input  wire vefm_pkg::vefm_crc_t     crc_chk,  // luma crc
    input  wire vefm_pkg::vefm_std_t     std_chk,  // standards
    input  wire vefm_pkg::vefm_ext_t     ext_evt,  // other detectors
    output logic [15:0]                  error_flags, // flag view
    output logic                         data_error   // combined
);
    import vefm_pkg::*;

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (NUM_FLAGS != `VEFM_NUM_FLAGS)
    begin : g_bad_flags
        $error("flag count must match the register layout");
    end

    // the highest flag must sit inside the flag vector
    if (`VEFM_STANDARD_BIT >= NUM_FLAGS)
    begin : g_bad_top_bit
        $error("standard flag lies outside the flag vector");
    end

    // flags and mask are both read back through one data word
    if (NUM_FLAGS > `VEFM_DATA_W)
    begin : g_bad_width
        $error("flag vector wider than the register word");
    end

    // a shared address would make a mask read clear the flags
    if (`VEFM_MASK_ADDR == `VEFM_FLAGS_ADDR)
    begin : g_bad_addr
        $error("mask and flag registers share an address");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // true when a timing code word breaks its protection bits
    function automatic logic xyz_bad(
        input logic [9:0] w,
        input logic       is_8bit
    );
        logic f;
        logic v;
        logic h;
        logic bad;
        f = w[`VEFM_XYZ_F_BIT];
        v = w[`VEFM_XYZ_V_BIT];
        h = w[`VEFM_XYZ_H_BIT];
        bad = !w[`VEFM_XYZ_ONE_BIT];
        bad = bad | (w[`VEFM_XYZ_P3_BIT] != (v ^ h));
        bad = bad | (w[`VEFM_XYZ_P2_BIT] != (f ^ h));
        bad = bad | (w[`VEFM_XYZ_P1_BIT] != (f ^ v));
        bad = bad | (w[`VEFM_XYZ_P0_BIT] != (f ^ v ^ h));
        // 8-bit words carry no meaning in the two low bits
        if (!is_8bit)
        begin
            bad = bad | (w[1:0] != 2'h0);
        end
        return bad;
    endfunction : xyz_bad

    // widen an 11-bit vector to the 16-bit register width
    function automatic logic [15:0] to_word(
        input logic [10:0] v
    );
        return {5'h00, v};
    endfunction : to_word

    // one host request aimed at one register address
    function automatic logic addr_hit(
        input logic [7:0] addr,
        input logic [7:0] target
    );
        return addr == target;
    endfunction : addr_hit

    // ------------------------------------------------------------
    // event detection
    // ------------------------------------------------------------
    logic        hd_mode;
    logic        trs_on;
    logic        luma_bad;
    logic        chroma_bad;
    logic        luma_is_eav;
    logic        chroma_is_eav;
    logic [10:0] set_vec;

    // rate indicator high means SD, so HD is its inverse
    assign hd_mode = !definition_rate_indicator;

    // timing code checks only run with the flywheel enabled
    assign trs_on = trs.valid && flywheel_enable_control; // R5

    // chroma words are checked in SD only, where no Y/C split exists
    assign luma_bad   = trs_on && xyz_bad(trs.luma_xyz, trs.is_8bit);
    assign chroma_bad = trs_on && !hd_mode
        && xyz_bad(trs.chroma_xyz, trs.is_8bit); // R4

    // the H bit tells an end code from a start code
    assign luma_is_eav   = trs.luma_xyz[`VEFM_XYZ_H_BIT];
    assign chroma_is_eav = trs.chroma_xyz[`VEFM_XYZ_H_BIT];

    // one set term per flag, all single-cycle except lock
    always_comb
    begin
        set_vec = 11'h000;
        set_vec[`VEFM_ACTIVE_END_BIT] =
            (luma_bad && luma_is_eav)
            || (chroma_bad && chroma_is_eav); // R2
        set_vec[`VEFM_ACTIVE_START_BIT] =
            (luma_bad && !luma_is_eav)
            || (chroma_bad && !chroma_is_eav); // R3
        set_vec[`VEFM_LINE_NUMBER_BIT] = hd_mode
            && line_chk.valid
            && (line_chk.computed != line_chk.received); // R1
        set_vec[`VEFM_LUMA_LINE_CRC_BIT] = hd_mode
            && crc_chk.valid
            && (crc_chk.computed != crc_chk.received); // R6 R12
        set_vec[`VEFM_CHROMA_CRC_BIT] = hd_mode
            && ext_evt.chroma_crc_err; // R12
        // chroma checksums exist only as a separate channel in HD
        set_vec[`VEFM_LUMA_CSUM_BIT] = ext_evt.luma_csum_err;
        set_vec[`VEFM_CHROMA_CSUM_BIT] = hd_mode
            && ext_evt.chroma_csum_err;
        // lock loss is a level, so it re-sets every cycle it lasts
        set_vec[`VEFM_LOCK_BIT] = !ext_evt.locked;
        // field crc checks belong to SD streams only
        set_vec[`VEFM_ACTIVE_PIC_BIT] = !hd_mode
            && ext_evt.active_pic_crc_err;
        set_vec[`VEFM_FULL_FIELD_BIT] = !hd_mode
            && ext_evt.full_field_crc_err;
        set_vec[`VEFM_STANDARD_BIT] = std_chk.valid
            && (std_chk.received != std_chk.determined); // R9
    end

    // ------------------------------------------------------------
    // host decode
    // ------------------------------------------------------------
    logic mask_wr;
    logic mask_rd;
    logic flags_rd;

    // writes to the flag address are dropped: flags are read-only
    assign mask_wr  = host_req.wr
        && addr_hit(host_req.addr, `VEFM_MASK_ADDR); // R7
    assign mask_rd  = host_req.rd
        && addr_hit(host_req.addr, `VEFM_MASK_ADDR);
    assign flags_rd = host_req.rd
        && addr_hit(host_req.addr, `VEFM_FLAGS_ADDR); // R11

    // ------------------------------------------------------------
    // mask register
    // ------------------------------------------------------------
    logic [10:0] mask_reg;
    logic [10:0] mask_next;

    // limitation: the mask only gates the combined pin, never a flag
    // upper bits of the written word have no storage
    always_comb
    begin
        mask_next = mask_reg;
        if (mask_wr)
        begin
            mask_next = host_req.wdata[10:0]; // R7 R8
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mask_reg <= `VEFM_MASK_RESET; // R7
        end
        else
        begin
            mask_reg <= mask_next;
        end
    end

    // ------------------------------------------------------------
    // flag register
    // ------------------------------------------------------------
    logic [10:0] flags_reg;
    logic [10:0] flags_next;

    // limitation: repeated events between two reads show as one
    // clear on read, but a new event in the read cycle survives
    always_comb
    begin
        flags_next = flags_reg;
        if (flags_rd)
        begin
            flags_next = 11'h000;
        end
        flags_next = flags_next | set_vec;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            flags_reg <= `VEFM_FLAGS_RESET; // R11
        end
        else
        begin
            flags_reg <= flags_next;
        end
    end

    // ------------------------------------------------------------
    // read data and combined error
    // ------------------------------------------------------------
    logic [15:0] rd_data_reg;
    logic [15:0] rd_data_next;
    logic        data_error_reg;
    logic        data_error_next;

    // read returns the value before any clear of the same cycle
    always_comb
    begin
        rd_data_next = rd_data_reg;
        if (mask_rd)
        begin
            rd_data_next = to_word(mask_reg); // R7
        end
        else if (flags_rd)
        begin
            rd_data_next = to_word(flags_reg); // R11
        end
        else if (host_req.rd)
        begin
            rd_data_next = 16'h0000;
        end
    end

    // masked flags stay visible but no longer raise the pin
    always_comb
    begin
        data_error_next = |(flags_next & ~mask_next); // R10 R8
    end

    // read data holds between reads, zero out of reset
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rd_data_reg <= 16'h0000;
        end
        else
        begin
            rd_data_reg <= rd_data_next;
        end
    end

    // combined error register, low out of reset
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            data_error_reg <= 1'b0;
        end
        else
        begin
            data_error_reg <= data_error_next;
        end
    end

    // outputs come straight from flops, no logic after them
    assign rd_data     = rd_data_reg;
    assign data_error  = data_error_reg;
    assign error_flags = to_word(flags_reg);

endmodule : vefm_error_bank

// file: dv/vefm_error_bank_assertions.sv
// Purpose: port checker of the error flag and mask bank
// Assumes: sees only the top ports, one clock domain
// Notes:   mask state is not visible, so masking is left to the bench
module vefm_error_bank_assertions #(
    parameter int NUM_FLAGS = 11  // flag count
) (
    input wire logic                     clk,      // clock
    input wire logic                     reset_n,  // async reset
    input wire vefm_pkg::vefm_host_req_t host_req, // host request
    input wire logic [15:0]              rd_data,  // read data
    input wire logic                     definition_rate_indicator, // rate
    input wire logic                     flywheel_enable_control,  // fw
    input wire vefm_pkg::vefm_trs_t      trs,      // timing codes
    input wire vefm_pkg::vefm_line_t     line_chk, // line numbers
    input wire vefm_pkg::vefm_crc_t      crc_chk,  // luma crc
    input wire vefm_pkg::vefm_std_t      std_chk,  // standards
    input wire vefm_pkg::vefm_ext_t      ext_evt,  // other detectors
    input wire logic [15:0]              error_flags, // flags
    input wire logic                     data_error   // combined
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------------------------
    // properties
    // ----------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_line_sets: assert property (line_chk.valid &&
        line_chk.computed != line_chk.received &&
        !definition_rate_indicator |=> error_flags[2])
        else $error("line flag not set");
    a_trs_end_sets: assert property (trs.valid &&
        flywheel_enable_control && trs.luma_xyz[6] &&
        !trs.luma_xyz[9] |=> error_flags[0])
        else $error("end code flag not set");
    a_trs_needs_fw: assert property ($rose(error_flags[0]) |->
        $past(trs.valid && flywheel_enable_control))
        else $error("end code flag without check");
    a_crc_sets: assert property (crc_chk.valid &&
        crc_chk.computed != crc_chk.received &&
        !definition_rate_indicator |=> error_flags[3])
        else $error("crc flag not set");
    a_std_sets: assert property (std_chk.valid &&
        std_chk.received != std_chk.determined |=> error_flags[10])
        else $error("standard flag not set");
    a_flags_upper: assert property (error_flags[15:11] == 5'h00)
        else $error("unused flag bits set");
    a_mask_upper: assert property (host_req.rd &&
        host_req.addr == 8'h1A |=> rd_data[15:11] == 5'h00)
        else $error("unused mask bits read back");
    a_error_cause: assert property (data_error |->
        error_flags[10:0] != 11'h000)
        else $error("combined error without flag");
    a_trs_start_sets: assert property (trs.valid &&
        flywheel_enable_control && !trs.luma_xyz[6] &&
        !trs.luma_xyz[9] |=> error_flags[1])
        else $error("start code flag not set");
    a_crc_needs_hd: assert property ($rose(error_flags[3]) |->
        $past(crc_chk.valid && !definition_rate_indicator))
        else $error("crc flag outside HD");
    a_read_flags: assert property (host_req.rd &&
        host_req.addr == 8'h1B |=> rd_data == $past(error_flags))
        else $error("flag read mismatch");
    // main scenarios reached
    c_line: cover property (line_chk.valid ##1 error_flags[2]);
    c_read: cover property (host_req.rd && host_req.addr == 8'h1B);
    c_error: cover property ($rose(data_error));
    c_masked: cover property (error_flags[0] && !data_error);
endmodule : vefm_error_bank_assertions

bind vefm_error_bank vefm_error_bank_assertions #(
    .NUM_FLAGS(NUM_FLAGS)
) chk_i (
    .clk(clk), .reset_n(reset_n), .host_req(host_req),
    .rd_data(rd_data),
    .definition_rate_indicator(definition_rate_indicator),
    .flywheel_enable_control(flywheel_enable_control),
    .trs(trs), .line_chk(line_chk), .crc_chk(crc_chk),
    .std_chk(std_chk), .ext_evt(ext_evt),
    .error_flags(error_flags), .data_error(data_error)
);

// file: dv/test_video_error_flag_mask_bank.sv
// Purpose: directed bench of the error flag and mask bank
// Assumes: one-cycle host strobes, answers one cycle later
// Notes:   lock held high so its flag stays quiet
module test_video_error_flag_mask_bank;
    timeunit 1ns;
    timeprecision 100ps;
    import vefm_pkg::*;
    // ----------------------------------------------------------
    // signals
    // ----------------------------------------------------------
    logic           clk;
    logic           reset_n;
    logic           rate;
    logic           fw;
    logic           derr;
    logic [15:0]    rd_data;
    logic [15:0]    flags;
    logic [15:0]    d;
    vefm_host_req_t req;
    vefm_trs_t      trs;
    vefm_line_t     ln;
    vefm_crc_t      crc;
    vefm_std_t      sd;
    vefm_ext_t      ext;
    int             n_errors;
    int             checks;
    int             ks[11] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10};

    vefm_error_bank vefm_error_bank_i (
        .clk(clk), .reset_n(reset_n), .host_req(req), .rd_data(rd_data),
        .definition_rate_indicator(rate), .flywheel_enable_control(fw),
        .trs(trs), .line_chk(ln), .crc_chk(crc), .std_chk(sd),
        .ext_evt(ext), .error_flags(flags), .data_error(derr)
    );

    // 4 ns word clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // good code word, s = f v h
    function automatic logic [9:0] xyz(logic [2:0] s);
        return {1'b1, s, s[1] ^ s[0], s[2] ^ s[0], s[2] ^ s[1], ^s, 2'b00};
    endfunction : xyz

    task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    // one host access; d holds the answer of a read
    task automatic access(logic w, logic [7:0] a, logic [15:0] wd);
        @(posedge clk);
        #1 req = '{w, !w, a, wd};
        @(posedge clk);
        #1 req = '0;
        d = rd_data;
    endtask : access

    // one detector strobe; flag is visible when it returns
    task automatic inject(int k);
        @(posedge clk);
        #1;
        case (k)
            0: trs = '{1'b1, 1'b0, xyz(3'h1) ^ 10'h200, xyz(3'h0)};
            1: trs = '{1'b1, 1'b0, xyz(3'h2) ^ 10'h200, xyz(3'h0)};
            2: ln = '{1'b1, 11'h005, 11'h006};
            3: crc = '{1'b1, 18'h00001, 18'h00002};
            4: ext.chroma_crc_err = 1'b1;
            5: ext.luma_csum_err = 1'b1;
            6: ext.chroma_csum_err = 1'b1;
            7: ext.locked = 1'b0;
            8: ext.active_pic_crc_err = 1'b1;
            9: ext.full_field_crc_err = 1'b1;
            10: sd = '{1'b1, 6'h01, 6'h02};
            11: trs = '{1'b1, 1'b0, xyz(3'h7), xyz(3'h0) ^ 10'h200};
            12: trs = '{1'b1, 1'b1, xyz(3'h5) | 10'h003, xyz(3'h0)};
            13: trs = '{1'b1, 1'b1, xyz(3'h5) ^ 10'h010, xyz(3'h0)};
            default: ;
        endcase
        @(posedge clk);
        #1 trs.valid = 1'b0;
        ln.valid = 1'b0;
        crc.valid = 1'b0;
        sd.valid = 1'b0;
        ext = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    endtask : inject

    // a hang ends the run as a failure
    initial
    begin
        #400000;
        n_errors++;
        end_sim();
    end

    // main sequence
    initial
    begin
        reset_n = 1'b0;
        rate = 1'b0;
        fw = 1'b1;
        req = '0;
        trs = '0;
        ln = '0;
        crc = '0;
        sd = '0;
        ext = '0;
        ext.locked = 1'b1;
        n_errors = 0;
        checks = 0;
        repeat (20) @(posedge clk);
        #1 reset_n = 1'b1;
        check("flags", flags, 16'h0000);
        access(1'b0, 8'h1A, 16'h0000);
        check("mask", d, 16'h0000);
        access(1'b1, 8'h1A, 16'hFFFF);
        access(1'b0, 8'h1A, 16'h0000);
        check("mask", d, 16'h07FF);
        access(1'b1, 8'h1B, 16'hFFFF);
        check("flags", flags, 16'h0000);
        access(1'b0, 8'h30, 16'h0000);
        check("unmapped", d, 16'h0000);
        $display("test registers done");
        foreach (ks[i])
        begin
            rate = ks[i] inside {8, 9};
            access(1'b1, 8'h1A, 16'h0001 << ks[i]);
            inject(ks[i]);
            check("flag", flags, 16'h0001 << ks[i]);
            check("masked", {15'h0000, derr}, 16'h0000);
            access(1'b0, 8'h1B, 16'h0000);
            check("read", d, 16'h0001 << ks[i]);
            check("cleared", flags, 16'h0000);
            access(1'b1, 8'h1A, ~(16'h0001 << ks[i]));
            inject(ks[i]);
            check("unmasked", {15'h0000, derr}, 16'h0001);
            access(1'b0, 8'h1B, 16'h0000);
        end
        $display("test flags done");
        rate = 1'b1;
        inject(2);
        inject(3);
        inject(4);
        check("sd quiet", flags, 16'h0000);
        rate = 1'b0;
        fw = 1'b0;
        inject(0);
        check("fw off", flags, 16'h0000);
        fw = 1'b1;
        inject(11);
        inject(12);
        check("ignored", flags, 16'h0000);
        access(1'b1, 8'h1A, 16'h0002);
        inject(13);
        check("8 bit", flags, 16'h0001);
        check("8 bit pin", {15'h0000, derr}, 16'h0001);
        $display("test refusals done");
        reset_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 reset_n = 1'b1;
        check("reset flags", flags, 16'h0000);
        check("reset pin", {15'h0000, derr}, 16'h0000);
        check("reset read", rd_data, 16'h0000);
        access(1'b0, 8'h1A, 16'h0000);
        check("reset mask", d, 16'h0000);
        $display("test reset done");
        end_sim();
    end
endmodule : test_video_error_flag_mask_bank
